// *** src/spc_count_step.sv ***
// Next-count arithmetic of the counter: one step with wrap, and terminal detect.
// Assumes a purely combinational context; the caller registers the results.
`timescale 1ns/1ps

module spc_count_step (
  input  logic [spc_pkg::CNT_W-1:0] count,
  input  logic                      decadeMode,
  output logic [spc_pkg::CNT_W-1:0] stepped,
  output logic                      wrapped,
  output logic                      isTerm
);

  // ----------------------------------------
  // Step and terminal detect
  // ----------------------------------------
  // The terminal value depends on the count length chosen.
  always_comb begin
    isTerm  = decadeMode ? (count == spc_pkg::TERM_DECADE)
                         : (count == spc_pkg::TERM_BINARY);
    wrapped = isTerm;
    // At the terminal count the next step returns to zero.
    if (isTerm) begin
      stepped = spc_pkg::CNT_ZERO;
    end else begin
      // Out-of-range decade values simply keep counting up.
      stepped = count + spc_pkg::CNT_ONE;
    end
  end

endmodule

// *** src/spc_counter.sv ***
// Presettable synchronous 4-bit counter with an Avalon-MM register slave.
// Assumes the control pins come from logic on clk; software sets the options.
//
// How it works
// R1: Decade or binary count length, software selected.
// R2: All four bits update on one edge.
// R3: Low load copies preset data next edge.
// R4: Asynchronous option: low clear zeroes count at once.
// R5: Synchronous option: low clear zeroes next edge.
// R6: Count only when both enables high.
// R7: Ripple carry gated by second enable.
// R8: Decade wraps nine to zero.
// R9: Binary wraps fifteen to zero.
// R10: Otherwise hold state across edges.
// R11: Mode decided only by levels at edge.
// R12: Partner avoids raising load while clock low.
// R13: Partner avoids raising clear while clock low.
// R14: Partner drops enables only while clock high.
// R15: Ripple carry equals enable and terminal count.
// R16: Synchronous clear beats simultaneous load.
//
// Chosen here: the register addresses and register access over Avalon-MM.
`timescale 1ns/1ps

module spc_counter (
  input  logic                       clk,
  input  logic                       nrst,
  input  spc_pkg::spc_pins_t         pins,
  input  logic [spc_pkg::ADDR_W-1:0] address,
  input  logic                       read,
  input  logic                       write,
  input  logic [spc_pkg::DATA_W-1:0] writedata,
  input  logic [spc_pkg::BE_W-1:0]   byteenable,
  output logic [spc_pkg::DATA_W-1:0] readdata,
  output logic                       waitrequest,
  output logic [spc_pkg::CNT_W-1:0]  count,
  output logic                       lsbOutput,
  output logic                       rippleCarry
);

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  spc_pkg::spc_ctrl_t          ctrlQ;       // Count length and clear option.
  spc_pkg::spc_ctrl_t          ctrlD;       // Control value after this edge.
  logic [spc_pkg::CNT_W-1:0]   countQ;      // Counter state.
  logic [spc_pkg::CNT_W-1:0]   countD;      // Next counter state.
  logic [spc_pkg::CNT_W-1:0]   stepped;     // Count plus one with wrap.
  logic                        wrapped;     // Present count is terminal.
  logic                        termNext;    // Next count will be terminal.
  logic                        terminalQ;   // Registered terminal flag.
  logic                        countRstN;   // Reset of the count flops.
  logic                        asyncClr;    // Asynchronous clear is acting.
  logic                        countEn;     // Count mode at this edge.
  logic                        wrapEv;      // A wrap happens at this edge.
  logic [spc_pkg::WRAP_W-1:0]  wrapsQ;      // Wrap events seen.
  logic                        waitQ;       // Registered waitrequest.
  logic [spc_pkg::DATA_W-1:0]  readdataQ;   // Registered read data.
  logic [spc_pkg::DATA_W-1:0]  rdMux;       // Read data selection.
  logic                        busReq;      // Any access pending.
  logic                        wrAccept;    // Write completes this edge.
  logic                        ctrlWr;      // Write to the control register.
  logic                        wrapsClr;    // Write to the wrap counter.

  // ----------------------------------------
  // Control register
  // ----------------------------------------
  // Software picks count length and clear option here.
  spc_reg_field #(
    .W     (spc_pkg::CTRL_W),
    .RESET (spc_pkg::CTRL_RESET)
  ) u_ctrl (
    .clk    (clk),
    .nrst   (nrst),
    .wrEn   (ctrlWr),
    .wrData (writedata[spc_pkg::CTRL_W-1:0]),
    .fieldQ (ctrlQ),
    .fieldD (ctrlD)
  );

  // ----------------------------------------
  // Count arithmetic
  // ----------------------------------------
  // Step from the present count under the present length option.
  spc_count_step u_step_now (
    .count      (countQ),
    .decadeMode (ctrlQ.decadeMode), // R1
    .stepped    (stepped),
    .wrapped    (wrapped),
    .isTerm     ()
  );

  // Look ahead: terminal test of the next count under the next option.
  // This keeps the carry flag in step with a length change by software.
  spc_count_step u_step_next (
    .count      (countD),
    .decadeMode (ctrlD.decadeMode),
    .stepped    (),
    .wrapped    (),
    .isTerm     (termNext)
  );

  // ----------------------------------------
  // Mode decode
  // ----------------------------------------
  // The clear pin acts without the clock only in the asynchronous option.
  always_comb begin
    asyncClr  = !pins.clrN && !ctrlQ.syncClear;
    countRstN = nrst && !asyncClr; // R4
    countEn   = pins.loadN && pins.clrN && pins.enP && pins.enT; // R6
    wrapEv    = countEn && wrapped;
  end

  // Next state, decided purely by the pin levels seen at the edge.
  // Clear first, then load, then count, else hold.
  always_comb begin // R11
    countD = countQ; // R10
    if (ctrlQ.syncClear && !pins.clrN) begin
      // Clear wins over a load in the same cycle.
      countD = spc_pkg::CNT_ZERO; // R5 R16
    end else if (!pins.loadN) begin
      // Load ignores both enables.
      countD = pins.presetData; // R3
    end else if (pins.enP && pins.enT) begin
      // Wraps at nine or fifteen come from the step logic.
      countD = stepped; // R6 R8 R9
    end
  end

  // ----------------------------------------
  // Count state
  // ----------------------------------------
  // All four bits share one clock edge, so no ripple spikes occur.
  // Hazard: countRstN is combinational; changing the clear option while
  // the pin is low may clear at once, which matches the new option.
  always_ff @(posedge clk or negedge countRstN) begin
    if (!countRstN) begin
      countQ    <= spc_pkg::CNT_ZERO; // R4
      terminalQ <= 1'b0;
    end else begin
      countQ    <= countD; // R2
      terminalQ <= termNext;
    end
  end

  // ----------------------------------------
  // Wrap event counter
  // ----------------------------------------
  // A wrap arriving with a clearing write still counts as one.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wrapsQ <= spc_pkg::WRAP_ZERO;
    end else if (wrapEv) begin
      wrapsQ <= wrapsClr ? spc_pkg::WRAP_ONE : (wrapsQ + spc_pkg::WRAP_ONE);
    end else if (wrapsClr) begin
      wrapsQ <= spc_pkg::WRAP_ZERO;
    end
  end

  // ----------------------------------------
  // Avalon-MM slave
  // ----------------------------------------
  // Every access waits one cycle, then completes with waitrequest low.
  always_comb begin
    busReq   = read || write;
    wrAccept = write && !waitQ;
    ctrlWr   = wrAccept && (address == spc_pkg::REG_CTRL)
               && byteenable[spc_pkg::BE_LOW];
    wrapsClr = wrAccept && (address == spc_pkg::REG_WRAPS)
               && (|byteenable);
  end

  // Waitrequest drops for one cycle, one edge after a request appears.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      waitQ <= 1'b1;
    end else if (!waitQ) begin
      // The access completes at this edge; idle again.
      waitQ <= 1'b1;
    end else if (busReq) begin
      waitQ <= 1'b0;
    end
  end

  // Read selection; unmapped addresses read as zero.
  always_comb begin
    rdMux = spc_pkg::RDATA_ZERO;
    if (address == spc_pkg::REG_CTRL) begin
      rdMux[spc_pkg::CTRL_W-1:0] = ctrlQ;
    end else if (address == spc_pkg::REG_STATUS) begin
      rdMux[spc_pkg::STAT_CNT_LSB +: spc_pkg::CNT_W] = countQ;
      rdMux[spc_pkg::STAT_RCO]  = rippleCarry;
      rdMux[spc_pkg::STAT_TERM] = terminalQ;
    end else if (address == spc_pkg::REG_WRAPS) begin
      rdMux[spc_pkg::WRAP_W-1:0] = wrapsQ;
    end
  end

  // Read data is captured as waitrequest falls and held until the next read.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      readdataQ <= spc_pkg::RDATA_ZERO;
    end else if (read && waitQ) begin
      readdataQ <= rdMux;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  // The carry must follow the second enable without a clock, so it is
  // the one output with a gate after its flip-flop.
  assign rippleCarry = pins.enT && terminalQ; // R7 R15
  assign count       = countQ;
  assign lsbOutput   = countQ[0];
  assign readdata    = readdataQ;
  assign waitrequest = waitQ;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  // Load copies the preset word at the next edge.
  property p_load_preset;
    @(posedge clk) disable iff (!nrst)
    (!pins.loadN && pins.clrN) |=>
      (asyncClr || (countQ == $past(pins.presetData)));
  endproperty
  a_load_preset: assert property (p_load_preset) // R3
    else $error("Load did not copy the preset data.");

  // An asynchronous clear shows at once.
  property p_async_clear;
    @(posedge clk) disable iff (!nrst)
    asyncClr |-> (countQ == spc_pkg::CNT_ZERO) && !rippleCarry;
  endproperty
  a_async_clear: assert property (p_async_clear) // R4
    else $error("Asynchronous clear did not zero the count.");

  // A synchronous clear zeroes the count even while counting is enabled.
  property p_sync_clear;
    @(posedge clk) disable iff (!nrst)
    (ctrlQ.syncClear && !pins.clrN && pins.enP && pins.enT) ##1 1'b1
      |-> (countQ == spc_pkg::CNT_ZERO);
  endproperty
  a_sync_clear: assert property (p_sync_clear) // R5
    else $error("Synchronous clear did not zero the count.");

  // Clear beats load when both are low.
  property p_clear_over_load;
    @(posedge clk) disable iff (!nrst)
    (ctrlQ.syncClear && !pins.clrN && !pins.loadN) |=>
      (countQ == spc_pkg::CNT_ZERO);
  endproperty
  a_clear_over_load: assert property (p_clear_over_load) // R16
    else $error("Load won over a synchronous clear.");

  // Counting adds one except at the decade terminal.
  property p_count_step;
    @(posedge clk) disable iff (!nrst)
    (countEn && !(ctrlQ.decadeMode && (countQ == spc_pkg::TERM_DECADE))) |=>
      (asyncClr || (countQ == $past(countQ) + spc_pkg::CNT_ONE));
  endproperty
  a_count_step: assert property (p_count_step) // R6
    else $error("Enabled count did not advance by one.");

  // Hold when either enable is low and nothing else acts.
  property p_hold;
    @(posedge clk) disable iff (!nrst)
    (pins.loadN && pins.clrN && !(pins.enP && pins.enT)) |=>
      (asyncClr || $stable(countQ));
  endproperty
  a_hold: assert property (p_hold) // R10
    else $error("Count changed while counting was inhibited.");

  // Decade wrap from nine to zero.
  property p_decade_wrap;
    @(posedge clk) disable iff (!nrst)
    (countEn && ctrlQ.decadeMode && (countQ == spc_pkg::TERM_DECADE)) |=>
      (countQ == spc_pkg::CNT_ZERO);
  endproperty
  a_decade_wrap: assert property (p_decade_wrap) // R8
    else $error("Decade count did not wrap from nine.");

  // Binary wrap from fifteen to zero.
  property p_binary_wrap;
    @(posedge clk) disable iff (!nrst)
    (countEn && !ctrlQ.decadeMode && (countQ == spc_pkg::TERM_BINARY)) |=>
      (countQ == spc_pkg::CNT_ZERO);
  endproperty
  a_binary_wrap: assert property (p_binary_wrap) // R9
    else $error("Binary count did not wrap from fifteen.");

  // A decade count in range stays in range while counting.
  property p_decade_range;
    @(posedge clk) disable iff (!nrst)
    (countEn && ctrlQ.decadeMode && (countQ <= spc_pkg::TERM_DECADE)) [*2]
      |=> (countQ <= spc_pkg::TERM_DECADE);
  endproperty
  a_decade_range: assert property (p_decade_range) // R1
    else $error("Decade count left the range zero to nine.");

  // Carry equals the second enable and the terminal count.
  property p_carry;
    @(posedge clk) disable iff (!nrst)
    rippleCarry == (pins.enT && (countQ == (ctrlQ.decadeMode ?
      spc_pkg::TERM_DECADE : spc_pkg::TERM_BINARY)));
  endproperty
  a_carry: assert property (p_carry) // R15
    else $error("Ripple carry does not match the terminal count.");

  // The carry stays low whenever the second enable is low.
  property p_carry_gate;
    @(posedge clk) disable iff (!nrst)
    !pins.enT |-> !rippleCarry;
  endproperty
  a_carry_gate: assert property (p_carry_gate) // R7
    else $error("Ripple carry was high with the second enable low.");

  // A synchronous clear also acts while counting is inhibited.
  property p_sync_clear_idle;
    @(posedge clk) disable iff (!nrst)
    (ctrlQ.syncClear && !pins.clrN && !(pins.enP && pins.enT)) |=>
      (countQ == spc_pkg::CNT_ZERO);
  endproperty
  a_sync_clear_idle: assert property (p_sync_clear_idle) // R5
    else $error("Synchronous clear did not act with the enables low.");

  // In the synchronous option a clear that falls between edges must not act
  // early: the count sampled at the next edge is still the held value.
  // A leak here would mean the clear pin reached the flops as a reset.
  property p_clear_waits;
    @(posedge clk) disable iff (!nrst)
    (ctrlQ.syncClear && !pins.clrN && $past(pins.clrN) && $past(pins.loadN)
      && !($past(pins.enP) && $past(pins.enT))) |-> (countQ == $past(countQ));
  endproperty
  a_clear_waits: assert property (p_clear_waits) // R11
    else $error("Synchronous clear acted before the clock edge.");

  // Each enabled wrap adds one to the wrap counter unless a write clears it.
  property p_wrap_count;
    @(posedge clk) disable iff (!nrst)
    (wrapEv && !wrapsClr) |=> (wrapsQ == $past(wrapsQ) + spc_pkg::WRAP_ONE);
  endproperty
  a_wrap_count: assert property (p_wrap_count) // R8 R9
    else $error("Wrap counter did not advance on a wrap.");

endmodule

// *** src/spc_pkg.sv ***
// Shared constants and carrier types of the presettable 4-bit counter.
// Assumes only a SystemVerilog compiler; every user names items as spc_pkg::name.
package spc_pkg;

  // ----------------------------------------
  // Widths
  // ----------------------------------------
  localparam int CNT_W  = 4;   // Count state width.
  localparam int ADDR_W = 4;   // Avalon byte address width.
  localparam int DATA_W = 32;  // Avalon data width.
  localparam int BE_W   = 4;   // Avalon byte enable width.
  localparam int WRAP_W = 16;  // Wrap event counter width.
  localparam int CTRL_W = 2;   // Control register width.

  // ----------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------
  localparam logic [ADDR_W-1:0] REG_CTRL   = 4'h0;
  localparam logic [ADDR_W-1:0] REG_STATUS = 4'h4;
  localparam logic [ADDR_W-1:0] REG_WRAPS  = 4'h8;

  // ----------------------------------------
  // Field positions and reset values
  // ----------------------------------------
  localparam int STAT_CNT_LSB = 0;  // Count in status bits 3:0.
  localparam int STAT_RCO     = 4;  // Ripple carry level.
  localparam int STAT_TERM    = 5;  // Terminal count flag.
  localparam int BE_LOW       = 0;  // Byte lane holding the control bits.
  localparam logic [CTRL_W-1:0] CTRL_RESET  = 2'h0;
  localparam logic [CNT_W-1:0]  CNT_ZERO    = 4'h0;
  localparam logic [CNT_W-1:0]  CNT_ONE     = 4'h1;
  localparam logic [CNT_W-1:0]  TERM_DECADE = 4'h9;
  localparam logic [CNT_W-1:0]  TERM_BINARY = 4'hf;
  localparam logic [WRAP_W-1:0] WRAP_ZERO   = 16'h0000;
  localparam logic [WRAP_W-1:0] WRAP_ONE    = 16'h0001;
  localparam logic [DATA_W-1:0] RDATA_ZERO  = 32'h0000_0000;

  // ----------------------------------------
  // Carrier types
  // ----------------------------------------
  // Control pins driven by the surrounding logic; loadN and clrN are active low.
  typedef struct packed {
    logic             loadN;
    logic             clrN;
    logic             enP;
    logic             enT;
    logic [CNT_W-1:0] presetData;
  } spc_pins_t;

  // Control register layout: bit 1 selects synchronous clear, bit 0 decade.
  typedef struct packed {
    logic syncClear;
    logic decadeMode;
  } spc_ctrl_t;

endpackage

// *** src/spc_reg_field.sv ***
// One software-writable register field with a reset value.
// Assumes the caller qualifies wrEn with address decode and byte enables.
`timescale 1ns/1ps

module spc_reg_field #(
  parameter int           W     = 1,
  parameter logic [W-1:0] RESET = '0
) (
  input  logic         clk,
  input  logic         nrst,
  input  logic         wrEn,
  input  logic [W-1:0] wrData,
  output logic [W-1:0] fieldQ,
  output logic [W-1:0] fieldD
);

  // Next value is exposed so users can look one edge ahead.
  always_comb begin
    fieldD = wrEn ? wrData : fieldQ;
  end

  // Field storage.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      fieldQ <= RESET;
    end else begin
      fieldQ <= fieldD;
    end
  end

endmodule

// *** verif/spc_counter_tb_top.sv ***
// Self-checking bench for the presettable counter and its register slave.
// Assumes the design answers each bus access within a few cycles.
`timescale 1ns/1ps

`define CHK(g, e) begin checksDone++; if ((g) !== (e)) begin errCount++; \
  $display("[FAIL] %0t ns: got %0h expected %0h", $time, (g), (e)); end end

module spc_counter_tb_top;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  localparam logic [3:0] C_HOLD = 4'h2; // Only enT high: state holds, carry visible.
  localparam logic [3:0] C_PEN  = 4'h1;
  localparam logic [3:0] C_CNT  = 4'h3;
  localparam logic [3:0] C_LOAD = 4'h4;
  localparam logic [3:0] C_CLR  = 4'h8;
  logic               clk;
  logic               nrst;
  spc_pkg::spc_pins_t pins;
  logic [3:0]         address;
  logic               read;
  logic               write;
  logic [31:0]        writedata;
  logic [3:0]         byteenable;
  logic [31:0]        readdata;
  logic               waitrequest;
  logic [3:0]         count;
  logic               lsbOutput;
  logic               rippleCarry;
  logic [3:0]         cmd;
  logic [3:0]         pdata;
  logic [31:0]        rdQ;
  int                 errCount;
  int                 checksDone;

  spc_pin_model u_spc_pin_model (.cmd(cmd), .data(pdata), .pins(pins));

  spc_counter u_spc_counter (
    .clk(clk), .nrst(nrst), .pins(pins), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(byteenable),
    .readdata(readdata), .waitrequest(waitrequest), .count(count),
    .lsbOutput(lsbOutput), .rippleCarry(rippleCarry)
  );

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  // Prints the verdict and ends the run; the only exit of the bench.
  task wrap_up;
    if (errCount == 0 && checksDone > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // One bus access; the request stands until waitrequest is seen low at an edge.
  task bus(input logic rd, input logic [3:0] a, input logic [31:0] d, input logic [3:0] be);
    int i;
    address    <= a;
    read       <= rd;
    write      <= ~rd;
    writedata  <= d;
    byteenable <= be;
    for (i = 0; i < 20; i++) begin
      @(posedge clk);
      if (waitrequest === 1'b0) break;
    end
    if (i == 20) begin
      errCount++;
      wrap_up();
    end
    rdQ = readdata;
    read  <= 1'b0;
    write <= 1'b0;
    // An idle edge keeps the strobes from being driven twice in one step.
    @(posedge clk);
  endtask

  task rd_chk(input logic [3:0] a, input logic [31:0] e);
    bus(1'b1, a, 32'h0000_0000, 4'hf);
    `CHK(rdQ, e)
  endtask

  // Applies a pin command for n edges, then falls back to holding.
  task run(input logic [3:0] c, input logic [3:0] d, input int n);
    cmd   <= c;
    pdata <= d;
    repeat (n) @(posedge clk);
    cmd <= C_HOLD;
  endtask

  // Samples the counter outputs mid-cycle, where they are settled.
  task look(input logic [3:0] e, input logic rc);
    @(negedge clk);
    `CHK(count, e)
    `CHK(lsbOutput, e[0])
    `CHK(rippleCarry, rc)
    @(posedge clk);
  endtask

  // ----------------------------------------
  // Clock and watchdog
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // Cuts a hang short; the bound is far above the length of the sequence.
  initial begin
    repeat (5000) @(posedge clk);
    errCount++;
    wrap_up();
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    errCount = 0; checksDone = 0; nrst = 1'b0; cmd = C_HOLD; pdata = 4'h0;
    address = 4'h0; read = 1'b0; write = 1'b0; writedata = 32'h0; byteenable = 4'h0;
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    look(4'h0, 1'b0);
    rd_chk(spc_pkg::REG_CTRL, 32'h0000_0000);
    rd_chk(4'hc, 32'h0000_0000);
    // Binary length with the asynchronous clear.
    run(C_LOAD, 4'hc, 1); look(4'hc, 1'b0);
    run(C_CNT, 4'h0, 3); look(4'hf, 1'b1);
    run(C_PEN, 4'h0, 3); look(4'hf, 1'b1);
    run(C_CNT, 4'h0, 1); look(4'h0, 1'b0);
    rd_chk(spc_pkg::REG_WRAPS, 32'h0000_0001);
    run(C_LOAD | C_CNT, 4'h5, 1); look(4'h5, 1'b0);
    cmd   <= C_CLR | C_LOAD | C_CNT;
    pdata <= 4'ha;
    #1 `CHK(count, 4'h0)
    @(posedge clk);
    cmd <= C_HOLD;
    look(4'h0, 1'b0);
    // Decade length with the synchronous clear; a write without lane 0 is dropped.
    bus(1'b0, spc_pkg::REG_CTRL, 32'h0000_0003, 4'hf);
    bus(1'b0, spc_pkg::REG_CTRL, 32'h0000_0000, 4'h0);
    rd_chk(spc_pkg::REG_CTRL, 32'h0000_0003);
    run(C_LOAD, 4'h7, 1); look(4'h7, 1'b0);
    run(C_CNT, 4'h0, 2); look(4'h9, 1'b1);
    run(C_CNT, 4'h0, 1); look(4'h0, 1'b0);
    run(C_CNT, 4'h0, 3); look(4'h3, 1'b0);
    cmd <= C_CLR | C_CNT;
    #1 `CHK(count, 4'h3)
    @(posedge clk);
    cmd <= C_HOLD;
    look(4'h0, 1'b0);
    run(C_CLR | C_LOAD, 4'h6, 1); look(4'h0, 1'b0);
    run(C_LOAD, 4'h9, 1); look(4'h9, 1'b1);
    rd_chk(spc_pkg::REG_STATUS, 32'h0000_0039);
    // With enT low the carry must drop although the count sits at nine.
    cmd <= C_PEN;
    @(negedge clk);
    `CHK(rippleCarry, 1'b0)
    `CHK(count, 4'h9)
    @(posedge clk);
    cmd <= C_HOLD;
    rd_chk(spc_pkg::REG_WRAPS, 32'h0000_0002);
    bus(1'b0, spc_pkg::REG_WRAPS, 32'h0000_0000, 4'hf);
    rd_chk(spc_pkg::REG_WRAPS, 32'h0000_0000);
    wrap_up();
  end
endmodule

// *** verif/spc_pin_model.sv ***
// Model of the surrounding control logic that drives the counter's pins.
// Assumes the bench changes cmd and data only just after a rising clock edge.
`timescale 1ns/1ps

module spc_pin_model (
  input  logic [3:0]         cmd,
  input  logic [3:0]         data,
  output spc_pkg::spc_pins_t pins
);
  // ----------------------------------------
  // Pin decode
  // ----------------------------------------
  // Command bits are active high: 0 enP, 1 enT, 2 load, 3 clear.
  // Every change follows a rising edge, so the clock is high when any pin moves.
  always_comb begin
    pins.enP       = cmd[0];
    pins.enT       = cmd[1];
    pins.loadN     = ~cmd[2];
    pins.clrN      = ~cmd[3];
    // Preset lines show the inverse when no load is asked, so stray loads show up.
    if (cmd[2]) begin
      pins.presetData = data;
    end else begin
      pins.presetData = ~data;
    end
  end
endmodule
